// ---- include/bpc_pkg.sv ----
// Package of constants and carrier types for the boost pulse control block.
package bpc_pkg;
  // ===========================================================================
  // Timing
  // ===========================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int UP_MIN_NS = 1000;
  localparam int UP_MAX_NS = 60000;
  localparam int DOWN_MIN_NS = 140000;
  localparam int DOWN_MAX_NS = 240000;
  localparam int OFF_MIN_NS = 560000;
  localparam int TON_MAX_NS = 6000;
  localparam int TOFF_MIN_NS = 400;
  localparam int UP_MIN_CYC = (UP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UP_MAX_CYC = UP_MAX_NS / CLK_PERIOD_NS;
  localparam int DOWN_MIN_CYC =
    (DOWN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DOWN_MAX_CYC = DOWN_MAX_NS / CLK_PERIOD_NS;
  localparam int OFF_MIN_CYC =
    (OFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TON_MAX_CYC = TON_MAX_NS / CLK_PERIOD_NS;
  localparam int TOFF_MIN_CYC =
    (TOFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ===========================================================================
  // Soft start and DAC
  // ===========================================================================
  localparam int SS_PHASE_CYCLES = 256;
  localparam int DAC_BITS = 6;
  localparam logic [5:0] DAC_CENTRE = 6'h1F;
  localparam logic [5:0] DAC_TOP = 6'h3F;
  localparam logic [1:0] ILIM_QUARTER = 2'h1;
  localparam logic [1:0] ILIM_HALF = 2'h2;
  localparam logic [1:0] ILIM_FULL = 2'h3;
  localparam logic [1:0] ILIM_NONE = 2'h0;

  typedef enum logic [1:0] {
    BPC_OFF, BPC_SOFT1, BPC_SOFT2, BPC_RUN
  } bpc_state_t;

  typedef struct packed {
    logic input_isolation_switch;
    logic main_power_switch;
    logic [1:0] ilim_sel;
  } bpc_power_t;
endpackage

// ---- verilog/bpc_ctrl.sv ----
// Pulse programmed control for a step-up converter.
`timescale 1ns/1ps
// Operation
// - Control pin going high during shutdown wakes device into soft start.
// - Current limit quarter for 256 switch cycles, then half for 256.
// - Control low for 560 us or longer shuts device down.
// - Input isolation switch stays open while shut down.
// - Low 1-60 us steps code up; 140-240 us steps code down.
// - DAC code is six bits, 64 values, zero lowest.
// - Every pin-triggered start loads DAC code with centre, 32nd step.
// - Code zero gives 0 V at DAC; top code gives reference.
// - Under undervoltage both switches stay open and device stays off.
// - Over temperature opens both switches; thermal shutdown.
// - Main switch on when feedback low, off at current limit.
// - Main switch on-time is cut off at about 6 us.
// - Off at least 400 ns and until feedback low again.
module bpc_ctrl #(
  parameter int OFF_CYC = bpc_pkg::OFF_MIN_CYC,
  parameter int DOWN_MAX = bpc_pkg::DOWN_MAX_CYC,
  parameter int DOWN_MIN = bpc_pkg::DOWN_MIN_CYC,
  parameter int UP_MAX = bpc_pkg::UP_MAX_CYC,
  parameter int UP_MIN = bpc_pkg::UP_MIN_CYC
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Host control pin
  input wire logic ctrl_pin_in,
  // Analog monitors
  input wire logic fb_below_ref_in,
  input wire logic ilim_reached_in,
  input wire logic uvlo_in,
  input wire logic over_temp_in,
  // Outputs
  output bpc_pkg::bpc_power_t power_out,
  output logic [5:0] dac_code_out,
  output logic device_on_out
);
  // ===========================================================================
  // Elaboration checks
  // ===========================================================================
  if (!(UP_MIN >= 1 && UP_MIN <= UP_MAX && UP_MAX < DOWN_MIN &&
        DOWN_MIN <= DOWN_MAX && DOWN_MAX < OFF_CYC && OFF_CYC < 2**20)) begin
    $error("bpc_ctrl: pulse width thresholds out of order");
  end

  // ===========================================================================
  // Control pin pulse measurement and operating state
  // ===========================================================================
  bpc_pkg::bpc_state_t state_r, state_nxt;
  logic ctrl_d_r, ctrl_d_nxt;
  logic [19:0] low_cnt_r, low_cnt_nxt;
  logic [5:0] dac_r, dac_nxt;
  logic [8:0] ss_cnt_r, ss_cnt_nxt;
  logic fault;
  logic sw_off_edge;

  assign fault = uvlo_in | over_temp_in;

  always_comb begin
    state_nxt = state_r;
    ctrl_d_nxt = ctrl_pin_in;
    low_cnt_nxt = low_cnt_r;
    dac_nxt = dac_r;
    ss_cnt_nxt = ss_cnt_r;
    if (!ctrl_pin_in && low_cnt_r != 20'(OFF_CYC)) begin
      low_cnt_nxt = low_cnt_r + 20'h1;
    end else if (ctrl_pin_in) begin
      low_cnt_nxt = 20'h0;
    end
    if (state_r != bpc_pkg::BPC_OFF && !ctrl_pin_in &&
        low_cnt_r == 20'(OFF_CYC - 1)) begin
      state_nxt = bpc_pkg::BPC_OFF;
    end else if (state_r == bpc_pkg::BPC_OFF) begin
      if (ctrl_pin_in && !ctrl_d_r && !fault) begin
        state_nxt = bpc_pkg::BPC_SOFT1;
        dac_nxt = bpc_pkg::DAC_CENTRE;
        ss_cnt_nxt = 9'h0;
      end
    end else if (ctrl_pin_in && !ctrl_d_r) begin
      // Pulse ended: classify its width; other widths are ignored.
      if (low_cnt_r >= 20'(UP_MIN) && low_cnt_r <= 20'(UP_MAX)) begin
        if (dac_r != bpc_pkg::DAC_TOP) begin
          dac_nxt = dac_r + 6'h1;
        end
      end else if (low_cnt_r >= 20'(DOWN_MIN) &&
                   low_cnt_r <= 20'(DOWN_MAX)) begin
        if (dac_r != 6'h0) begin
          dac_nxt = dac_r - 6'h1;
        end
      end
    end
    if (state_r == bpc_pkg::BPC_SOFT1 || state_r == bpc_pkg::BPC_SOFT2) begin
      if (sw_off_edge && state_nxt == state_r) begin
        ss_cnt_nxt = ss_cnt_r + 9'h1;
        if (ss_cnt_r == 9'(bpc_pkg::SS_PHASE_CYCLES - 1)) begin
          ss_cnt_nxt = 9'h0;
          state_nxt = (state_r == bpc_pkg::BPC_SOFT1) ?
                      bpc_pkg::BPC_SOFT2 : bpc_pkg::BPC_RUN;
        end
      end
    end
    if (fault) begin
      state_nxt = bpc_pkg::BPC_OFF;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= bpc_pkg::BPC_OFF;
      ctrl_d_r <= 1'b0;
      low_cnt_r <= 20'h0;
      dac_r <= bpc_pkg::DAC_CENTRE;
      ss_cnt_r <= 9'h0;
    end else begin
      state_r <= state_nxt;
      ctrl_d_r <= ctrl_d_nxt;
      low_cnt_r <= low_cnt_nxt;
      dac_r <= dac_nxt;
      ss_cnt_r <= ss_cnt_nxt;
    end
  end

  // ===========================================================================
  // Main switch on-time and off-time control
  // ===========================================================================
  logic sw_on_r, sw_on_nxt;
  logic [9:0] t_cnt_r, t_cnt_nxt;
  logic active;

  assign active = state_r != bpc_pkg::BPC_OFF && !fault;

  always_comb begin
    sw_on_nxt = sw_on_r;
    t_cnt_nxt = t_cnt_r;
    if (!active) begin
      sw_on_nxt = 1'b0;
      t_cnt_nxt = 10'h0;
    end else if (sw_on_r) begin
      t_cnt_nxt = t_cnt_r + 10'h1;
      if (ilim_reached_in ||
          t_cnt_r == 10'(bpc_pkg::TON_MAX_CYC - 1)) begin
        sw_on_nxt = 1'b0;
        t_cnt_nxt = 10'h0;
      end
    end else if (t_cnt_r < 10'(bpc_pkg::TOFF_MIN_CYC)) begin
      t_cnt_nxt = t_cnt_r + 10'h1;
    end else if (fb_below_ref_in) begin
      sw_on_nxt = 1'b1;
      t_cnt_nxt = 10'h0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sw_on_r <= 1'b0;
      t_cnt_r <= 10'h0;
    end else begin
      sw_on_r <= sw_on_nxt;
      t_cnt_r <= t_cnt_nxt;
    end
  end

  assign sw_off_edge = sw_on_r && !sw_on_nxt;

  // ===========================================================================
  // Outputs
  // ===========================================================================
  // DAC output is code * Vref / 63; code zero is 0 V.
  assign dac_code_out = dac_r;
  assign device_on_out = state_r != bpc_pkg::BPC_OFF;
  logic [1:0] ilim_code;
  assign ilim_code =
    (state_r == bpc_pkg::BPC_SOFT1) ? bpc_pkg::ILIM_QUARTER :
    (state_r == bpc_pkg::BPC_SOFT2) ? bpc_pkg::ILIM_HALF :
    (state_r == bpc_pkg::BPC_RUN) ? bpc_pkg::ILIM_FULL : bpc_pkg::ILIM_NONE;
  // A fault opens both switches in the same cycle.
  assign power_out = '{input_isolation_switch: active,
                       main_power_switch: sw_on_r & ~fault,
                       ilim_sel: ilim_code};

  // ===========================================================================
  // Assertions
  // ===========================================================================
  a_off_isolates: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    !device_on_out |-> !power_out.input_isolation_switch)
    else $error("Input switch closed while off.");
  a_fault_opens: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    fault |-> (!power_out.input_isolation_switch &&
    !power_out.main_power_switch) ##1 (!sw_on_r && !device_on_out))
    else $error("Switch closed under fault.");
  a_start_centre: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    state_r == bpc_pkg::BPC_OFF && state_nxt == bpc_pkg::BPC_SOFT1
    |=> dac_code_out == bpc_pkg::DAC_CENTRE)
    else $error("Start did not load centre code.");
  a_long_low_off: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    !ctrl_pin_in && low_cnt_r == 20'(OFF_CYC - 1) |=> !device_on_out)
    else $error("Long low did not shut down.");
  a_code_step: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    device_on_out && $past(device_on_out) && dac_r != $past(dac_r) |->
    (dac_r == $past(dac_r) + 6'h1 || dac_r == $past(dac_r) - 6'h1))
    else $error("DAC code moved by more than one step.");
  a_no_wrap: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    state_r != bpc_pkg::BPC_OFF && state_nxt != bpc_pkg::BPC_OFF &&
    dac_r == bpc_pkg::DAC_TOP |=> dac_r != 6'h0)
    else $error("DAC code wrapped.");
  a_no_underflow: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    state_r != bpc_pkg::BPC_OFF && state_nxt != bpc_pkg::BPC_OFF &&
    dac_r == 6'h0 |=> dac_r != bpc_pkg::DAC_TOP)
    else $error("DAC code wrapped below zero.");
  a_ton_max: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    sw_on_r |-> t_cnt_r < 10'(bpc_pkg::TON_MAX_CYC))
    else $error("On-time exceeded limit.");
  a_ilim_off: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    sw_on_r && ilim_reached_in |=> !sw_on_r)
    else $error("Switch stayed on at current limit.");
  a_toff_min: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    $fell(sw_on_r) |-> !sw_on_r [*8])
    else $error("Off-time too short.");
  a_toff_count: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(sw_on_r) |-> $past(t_cnt_r) >= 10'(bpc_pkg::TOFF_MIN_CYC))
    else $error("Switch turned on before minimum off-time.");
  a_soft_order: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    state_r == bpc_pkg::BPC_SOFT2 |-> $past(state_r) != bpc_pkg::BPC_OFF &&
    $past(state_r) != bpc_pkg::BPC_RUN)
    else $error("Half limit phase entered out of order.");
  a_odd_pulse: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    device_on_out && ctrl_pin_in && !ctrl_d_r && low_cnt_r > 20'(UP_MAX) &&
    low_cnt_r < 20'(DOWN_MIN) |=> dac_r == $past(dac_r))
    else $error("Out of range pulse changed code.");
endmodule // bpc_ctrl

// ---- verification/bpc_host_model.sv ----
// Host GPIO model that drives the control pin with timed low pulses.
`timescale 1ns/1ps
module bpc_host_model #(
  parameter int GAP_CYC = 100
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Pulse request
  input wire logic req_in,
  input wire logic stay_low_in,
  input wire logic [15:0] low_cyc_in,
  // Pin and status
  output logic ctrl_pin_out,
  output logic busy_out
);
  // ===========================================================================
  // Pulse generator
  // ===========================================================================
  int cnt_r;
  logic low_r;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_pin_out <= 1'b0;
      busy_out <= 1'b0;
      cnt_r <= 0;
      low_r <= 1'b0;
    end else if (!busy_out) begin
      if (req_in) begin
        busy_out <= 1'b1;
        ctrl_pin_out <= 1'b0;
        low_r <= 1'b1;
        cnt_r <= int'(low_cyc_in);
      end
    end else if (low_r) begin
      if (cnt_r <= 1) begin
        low_r <= 1'b0;
        if (stay_low_in) begin
          busy_out <= 1'b0;
        end else begin
          ctrl_pin_out <= 1'b1;
          cnt_r <= GAP_CYC;
        end
      end else begin
        cnt_r <= cnt_r - 1;
      end
    end else if (cnt_r <= 1) begin
      busy_out <= 1'b0;
    end else begin
      cnt_r <= cnt_r - 1;
    end
  end
endmodule // bpc_host_model

// ---- verification/test_boost_pulse_programmed_control.sv ----
// Self-checking testbench for the pulse programmed converter control.
`timescale 1ns/1ps
module test_boost_pulse_programmed_control;
  // ===========================================================================
  // Signals and instances
  // ===========================================================================
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic fb = 1'b0, ilim = 1'b0, uvlo = 1'b0, ot = 1'b0, auto_ilim = 1'b0;
  logic req = 1'b0, stay = 1'b0, ctrl, busy, dev_on;
  logic [15:0] width = 16'h0000;
  logic [5:0] dac;
  bpc_pkg::bpc_power_t pwr;
  int error_cnt = 0;
  int cmp_count = 0;
  bpc_ctrl #(.OFF_CYC(50), .DOWN_MAX(30), .DOWN_MIN(20), .UP_MAX(10),
    .UP_MIN(2)) i_bpc_ctrl (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .ctrl_pin_in(ctrl), .fb_below_ref_in(fb), .ilim_reached_in(ilim),
    .uvlo_in(uvlo), .over_temp_in(ot), .power_out(pwr),
    .dac_code_out(dac), .device_on_out(dev_on));
  bpc_host_model i_bpc_host_model (.sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in), .req_in(req), .stay_low_in(stay),
    .low_cyc_in(width), .ctrl_pin_out(ctrl), .busy_out(busy));
  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    #1 ilim = auto_ilim & pwr.main_power_switch;
  end
  // ===========================================================================
  // Helpers
  // ===========================================================================
  task automatic chk(input string what, input logic [7:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic pulse(input int w, input logic s);
    int k;
    tick(1);
    req = 1'b1;
    width = w[15:0];
    stay = s;
    for (k = 0; k < 10 && !busy; k++) tick(1);
    req = 1'b0;
    for (k = 0; k < 2000 && busy; k++) tick(1);
    chk("host done", 8'h00, {7'h00, busy});
  endtask
  task automatic wait_main(input logic v, input int lim, output int n);
    for (n = 0; n < lim && pwr.main_power_switch !== v; n++) tick(1);
    if (n >= lim) chk("switch wait", {7'h00, v}, {7'h00, ~v});
  endtask
  // ===========================================================================
  // Scenarios
  // ===========================================================================
  task automatic t_start;
    chk("isolation off", 8'h00, pwr.input_isolation_switch);
    pulse(1, 1'b0);
    chk("device on", 8'h01, dev_on);
    chk("dac centre", 8'h1F, dac);
  endtask
  task automatic t_soft;
    int i, n;
    logic [1:0] exp_sel;
    fb = 1'b1;
    auto_ilim = 1'b1;
    for (i = 0; i < 3 * bpc_pkg::SS_PHASE_CYCLES; i++) begin
      wait_main(1'b1, 200, n);
      if (i > 0) chk("off time", 8'h01, n >= bpc_pkg::TOFF_MIN_CYC);
      exp_sel = (i < bpc_pkg::SS_PHASE_CYCLES) ? bpc_pkg::ILIM_QUARTER :
        (i < 2 * bpc_pkg::SS_PHASE_CYCLES) ? bpc_pkg::ILIM_HALF :
        bpc_pkg::ILIM_FULL;
      chk("ilim sel", {6'h00, exp_sel}, {6'h00, pwr.ilim_sel});
      wait_main(1'b0, 20, n);
    end
    fb = 1'b0;
    auto_ilim = 1'b0;
    tick(60);
    chk("switch idle", 8'h00, pwr.main_power_switch);
  endtask
  task automatic t_ontime;
    int n;
    fb = 1'b1;
    wait_main(1'b1, 100, n);
    wait_main(1'b0, 700, n);
    chk("on time cut", 8'h01, n == bpc_pkg::TON_MAX_CYC);
    fb = 1'b0;
    tick(50);
  endtask
  task automatic t_steps;
    pulse(5, 1'b0);
    chk("step up", 8'h20, dac);
    pulse(25, 1'b0);
    chk("step down", 8'h1F, dac);
    pulse(15, 1'b0);
    pulse(40, 1'b0);
    chk("gap widths", 8'h1F, dac);
    chk("still on", 8'h01, dev_on);
  endtask
  task automatic t_limits;
    int i;
    for (i = 0; i < 33; i++) pulse(5, 1'b0);
    chk("top code", 8'h3F, dac);
    for (i = 0; i < 65; i++) pulse(25, 1'b0);
    chk("bottom code", 8'h00, dac);
  endtask
  task automatic t_fault(input logic is_uv);
    if (is_uv) uvlo = 1'b1;
    else ot = 1'b1;
    #1;
    chk("fault isolation", 8'h00, pwr.input_isolation_switch);
    tick(1);
    chk("fault off", 8'h00, dev_on);
    chk("fault switch", 8'h00, pwr.main_power_switch);
    pulse(5, 1'b0);
    chk("fault hold", 8'h00, dev_on);
    uvlo = 1'b0;
    ot = 1'b0;
    pulse(5, 1'b0);
    chk("restart", 8'h01, dev_on);
    chk("restart dac", 8'h1F, dac);
  endtask
  task automatic t_shut;
    pulse(60, 1'b1);
    chk("shutdown", 8'h00, dev_on);
    chk("shut isolation", 8'h00, pwr.input_isolation_switch);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #900000;
    error_cnt++;
    $display("mismatch watchdog expected done seen timeout");
    print_verdict();
  end
  initial begin
    tick(20);
    chk("reset dac", 8'h1F, dac);
    chk("reset power", 8'h00, pwr);
    rst_n_in = 1'b1;
    t_start();
    t_soft();
    t_ontime();
    t_steps();
    t_limits();
    t_fault(1'b1);
    t_fault(1'b0);
    t_shut();
    print_verdict();
  end
endmodule // test_boost_pulse_programmed_control
